// *** common/pcpc_pkg.sv ***
/*
  Shared constants and types for the per-channel push-button command block.
  Assumes a command-code register port driven by the serial-interface engine.
*/
`default_nettype none

package pcpc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_RESTART = 8'h18;  // detect_class_restart_trigger
  localparam logic [7:0] ADDR_POWER = 8'h19;    // channel_power_request
  localparam logic [7:0] RESTART_RESET = 8'h00;
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [7:0] READ_VALUE = 8'h00;    // Write-only registers read as zero

  // ----------------------------------------------------------------------
  // Field layout (four channels per register)
  // ----------------------------------------------------------------------
  localparam int NUM_CHAN = 4;
  localparam int DET_RESTART_LSB = 0;
  localparam int CLS_RESTART_LSB = 4;
  localparam int ON_REQ_LSB = 0;
  localparam int OFF_REQ_LSB = 4;

  // ----------------------------------------------------------------------
  // Operating modes and channel sequence states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_SEMI = 2'h2,
    MODE_AUTO = 2'h3
  } pcpc_mode_type;

  // Gray along idle -> detect -> classify
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_DET = 2'h1,
    SEQ_CLS = 2'h3
  } pcpc_seq_type;

endpackage

`default_nettype wire

// *** hdl/pcpc_chan_seq.sv ***
/*
  One channel of the push-button command engine: holds pending restarts,
  runs the one-shot detect/classify/turn-on attempt and issues pulses.
  Assumes all inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pcpc_chan_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic det_req,
  input wire logic cls_req,
  input wire logic on_req,
  input wire logic off_req,
  input wire logic cool,
  input wire logic disc,
  input wire logic both_en,
  input wire logic class_busy,
  input wire logic det_done,
  input wire logic det_valid,
  input wire logic cls_done,
  input wire logic cls_valid,
  input wire logic alloc_ok,
  output logic det_start,
  output logic cls_start,
  output logic det_en_set,
  output logic cls_en_set,
  output logic on_pulse,
  output logic off_pulse
);
  import pcpc_pkg::*;

  typedef struct packed {
    pcpc_seq_type state;
    logic det_pend;
    logic cls_pend;
    logic armed;
    logic det_start;
    logic cls_start;
    logic det_en_set;
    logic cls_en_set;
    logic on_pulse;
    logic off_pulse;
  } pcpc_chan_state_type;

  pcpc_chan_state_type s_reg;
  pcpc_chan_state_type s_next;
  pcpc_mode_type md;
  logic det_now;
  logic cls_now;
  logic blocked;
  logic good_cls;

  assign md = pcpc_mode_type'(mode);
  assign det_now = s_reg.det_pend | det_req;
  assign cls_now = s_reg.cls_pend | cls_req;
  assign blocked = cool | disc;
  assign good_cls = cls_done & cls_valid & alloc_ok;

  // Next-state: sequence first, then aborts, then fresh requests
  always_comb begin
    s_next = s_reg;
    s_next.det_start = 1'b0;
    s_next.cls_start = 1'b0;
    s_next.det_en_set = 1'b0;
    s_next.cls_en_set = 1'b0;
    s_next.on_pulse = 1'b0;
    s_next.off_pulse = 1'b0;
    // single attempt, a bad result ends it
    case (s_reg.state)
      SEQ_DET: begin
        if (det_done) begin
          if (det_valid) begin
            s_next.state = SEQ_CLS;
            s_next.cls_start = 1'b1;
          end else begin
            s_next.state = SEQ_IDLE;
          end
        end
      end
      SEQ_CLS: begin
        if (cls_done) begin
          s_next.state = SEQ_IDLE;
          s_next.on_pulse = good_cls;
        end
      end
      default: begin
      end
    endcase
    // armed request powers after this classification
    if (s_reg.armed && cls_done) begin
      s_next.armed = 1'b0;
      if (good_cls) begin
        s_next.on_pulse = 1'b1;
      end
    end
    // auto cycling powers without any request
    if (md == MODE_AUTO && both_en && good_cls) begin
      s_next.on_pulse = 1'b1;
    end
    // fault timing and disconnect abort any attempt
    if (blocked || md == MODE_OFF) begin
      s_next.state = SEQ_IDLE;
      s_next.armed = 1'b0;
      s_next.on_pulse = 1'b0;
      s_next.cls_start = 1'b0;
      s_next.det_start = 1'b0;
    end
    if (md == MODE_OFF) begin
      s_next.det_pend = 1'b0;
      s_next.cls_pend = 1'b0;
    end else if (cool) begin
      s_next.det_pend = det_now;
      s_next.cls_pend = cls_now;
    end else begin
      s_next.det_pend = 1'b0;
      s_next.cls_pend = 1'b0;
      if (md == MODE_MANUAL) begin
        s_next.det_start = s_next.det_start | det_now;
        s_next.cls_start = s_next.cls_start | cls_now;
      end else begin
        // semi-auto and auto turn on cycling enables instead
        s_next.det_en_set = det_now;
        s_next.cls_en_set = cls_now;
      end
    end
    // power requests ignored in off mode
    if (md != MODE_OFF) begin
      if (off_req) begin
        // off wins over on in the same write
        s_next.off_pulse = 1'b1;
        s_next.on_pulse = 1'b0;
        s_next.state = SEQ_IDLE;
        s_next.armed = 1'b0;
      end else if (on_req && !blocked) begin
        case (md)
          MODE_MANUAL: begin
            s_next.on_pulse = 1'b1;
          end
          MODE_SEMI: begin
            if (both_en && !class_busy) begin
              s_next.armed = 1'b1;
            end else begin
              s_next.state = SEQ_DET;
              s_next.det_start = 1'b1;
            end
          end
          default: begin
            // auto with an enable cleared runs one cycle
            if (!both_en) begin
              s_next.state = SEQ_DET;
              s_next.det_start = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign det_start = s_reg.det_start;
  assign cls_start = s_reg.cls_start;
  assign det_en_set = s_reg.det_en_set;
  assign cls_en_set = s_reg.cls_en_set;
  assign on_pulse = s_reg.on_pulse;
  assign off_pulse = s_reg.off_pulse;

endmodule

`default_nettype wire

// *** hdl/pcpc_push_cmd.sv ***
/*
  Push-button command block for one group of four power-sourcing channels:
  decodes writes to the restart and power-request registers and drives
  per-channel start, enable-set and power pulses.
  Assumes a same-clock command-code register port from the serial engine,
  and status inputs from the channel analog controllers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pcpc_push_cmd #(
  parameter int NUM_CHAN = pcpc_pkg::NUM_CHAN
) (
  input wire logic clk,
  input wire logic rst,
  // Command-code register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  // Channel mode, two bits per channel
  input wire logic [2*NUM_CHAN-1:0] chan_mode,
  input wire logic [NUM_CHAN-1:0] class_cycle_en,
  input wire logic [NUM_CHAN-1:0] detect_cycle_en,
  input wire logic [NUM_CHAN-1:0] overload_cooldown,
  input wire logic [NUM_CHAN-1:0] current_limit_cooldown,
  input wire logic [NUM_CHAN-1:0] startup_fault_cooldown,
  input wire logic [NUM_CHAN-1:0] chan_disconnect,
  input wire logic [NUM_CHAN-1:0] class_busy,
  input wire logic [NUM_CHAN-1:0] det_done,
  input wire logic [NUM_CHAN-1:0] det_valid,
  input wire logic [NUM_CHAN-1:0] cls_done,
  input wire logic [NUM_CHAN-1:0] cls_valid,
  input wire logic [NUM_CHAN-1:0] alloc_ok,
  // Pulses to the channel controllers
  output logic [NUM_CHAN-1:0] det_start,
  output logic [NUM_CHAN-1:0] cls_start,
  output logic [NUM_CHAN-1:0] det_en_set,
  output logic [NUM_CHAN-1:0] cls_en_set,
  output logic [NUM_CHAN-1:0] chan_power_on,
  output logic [NUM_CHAN-1:0] chan_power_off
);
  import pcpc_pkg::*;

  // ----------------------------------------------------------------------
  // Register-port state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic ack;
  } pcpc_port_state_type;

  pcpc_port_state_type p_reg;
  pcpc_port_state_type p_next;

  logic wr_restart;
  logic wr_power;
  logic hit;
  logic [NUM_CHAN-1:0] detect_restart_req;
  logic [NUM_CHAN-1:0] class_restart_req;
  logic [NUM_CHAN-1:0] chan_on_req;
  logic [NUM_CHAN-1:0] chan_off_req;
  logic [NUM_CHAN-1:0] cool;
  logic [NUM_CHAN-1:0] both_en;

  // Address decode; writes act only for the one cycle of reg_wr
  assign wr_restart = reg_wr & (reg_addr == ADDR_RESTART);
  assign wr_power = reg_wr & (reg_addr == ADDR_POWER);
  assign hit = (reg_addr == ADDR_RESTART) | (reg_addr == ADDR_POWER);

  // split restart byte into class and detect halves
  assign detect_restart_req = wr_restart ? reg_wdata[DET_RESTART_LSB +: NUM_CHAN] : '0;
  assign class_restart_req = wr_restart ? reg_wdata[CLS_RESTART_LSB +: NUM_CHAN] : '0;
  // upper half of power byte requests off
  assign chan_off_req = wr_power ? reg_wdata[OFF_REQ_LSB +: NUM_CHAN] : '0;
  // lower half of power byte requests on
  assign chan_on_req = wr_power ? reg_wdata[ON_REQ_LSB +: NUM_CHAN] : '0;

  // Any of the three cool-down timers holds the channel
  assign cool = overload_cooldown | current_limit_cooldown | startup_fault_cooldown;
  assign both_en = class_cycle_en & detect_cycle_en;

  // Read answer; unmapped addresses are not acknowledged
  always_comb begin
    p_next = p_reg;
    p_next.ack = (reg_wr | reg_rd) & hit;
    // these registers always read back as zero
    p_next.rdata = READ_VALUE;
  end

  // Port register
  always_ff @(posedge clk) begin
    if (rst) begin
      p_reg <= '0;
    end else begin
      p_reg <= p_next;
    end
  end

  assign reg_rdata = p_reg.rdata;
  assign reg_ack = p_reg.ack;

  // ----------------------------------------------------------------------
  // Per-channel engines
  // ----------------------------------------------------------------------
  // requests live one cycle here; the engine holds what must wait
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    // each bit drives only its own channel engine
    pcpc_chan_seq u_seq (
      .clk(clk),
      .rst(rst),
      .mode(chan_mode[2*i +: 2]),
      .det_req(detect_restart_req[i]),
      .cls_req(class_restart_req[i]),
      .on_req(chan_on_req[i]),
      .off_req(chan_off_req[i]),
      .cool(cool[i]),
      .disc(chan_disconnect[i]),
      .both_en(both_en[i]),
      .class_busy(class_busy[i]),
      .det_done(det_done[i]),
      .det_valid(det_valid[i]),
      .cls_done(cls_done[i]),
      .cls_valid(cls_valid[i]),
      .alloc_ok(alloc_ok[i]),
      .det_start(det_start[i]),
      .cls_start(cls_start[i]),
      .det_en_set(det_en_set[i]),
      .cls_en_set(cls_en_set[i]),
      .on_pulse(chan_power_on[i]),
      .off_pulse(chan_power_off[i])
    );
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // reads of either register answer zero
  a_read_zero: assert property (
    (reg_rd && hit) |=> (reg_ack && reg_rdata == 8'h00))
    else $error("push-button register read not zero");

  // a mapped write is always answered
  a_write_ack: assert property (
    (reg_wr && hit) |=> reg_ack)
    else $error("mapped write not acknowledged");

  a_miss_no_ack: assert property (
    !hit |=> !reg_ack)
    else $error("unmapped code acknowledged");

  // every answer carries a zero byte
  a_ack_zero_data: assert property (
    reg_ack |-> (reg_rdata == 8'h00))
    else $error("acknowledged data not zero");

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chk
    logic man;
    logic semi;
    logic auto_m;
    logic off_m;
    assign man = chan_mode[2*i +: 2] == MODE_MANUAL;
    assign semi = chan_mode[2*i +: 2] == MODE_SEMI;
    assign auto_m = chan_mode[2*i +: 2] == MODE_AUTO;
    assign off_m = chan_mode[2*i +: 2] == MODE_OFF;

    // Restart written while cooling, cooling ends next cycle
    sequence s_held_restart;
      (man && cool[i] && detect_restart_req[i]) ##1 (man && !cool[i]);
    endsequence

    // Auto cycling finishes with a usable class result
    sequence s_auto_good;
      auto_m && both_en[i] && cls_done[i] && cls_valid[i] && alloc_ok[i]
        && !cool[i] && !chan_disconnect[i] && !chan_off_req[i];
    endsequence

    // manual restart fires one detection start
    a_manual_restart: assert property (
      (man && detect_restart_req[i] && !cool[i]) |=> det_start[i])
      else $error("manual restart did not start detection");

    // semi-auto restart sets the enable, not a cycle
    a_semi_enable_set: assert property (
      (semi && class_restart_req[i] && !cool[i])
        |=> (cls_en_set[i] && !cls_start[i]))
      else $error("semi-auto restart did not set class enable");

    // no start while cooling, then the held request runs
    a_cool_no_start: assert property (
      cool[i] |=> (!det_start[i] && !cls_start[i]))
      else $error("cycle started during cool-down");
    a_cool_release: assert property (
      s_held_restart |=> det_start[i])
      else $error("held restart lost after cool-down");

    // off mode produces no power pulses
    a_off_mode_quiet: assert property (
      off_m |=> (!chan_power_on[i] && !chan_power_off[i]))
      else $error("power pulse in off mode");

    // both bits in one write turn the channel off
    a_off_wins: assert property (
      (!off_m && chan_on_req[i] && chan_off_req[i])
        |=> (chan_power_off[i] && !chan_power_on[i]))
      else $error("on and off together did not turn off");

    // power-on during cool-down: no turn-on next cycle, no detection start the cycle after
    a_on_in_cool: assert property (
      (chan_on_req[i] && cool[i]) |=> !chan_power_on[i] ##1 !det_start[i])
      else $error("power-on acted during cool-down");

    // diagnostic power-on acts the next cycle
    a_diag_on_now: assert property (
      (man && chan_on_req[i] && !chan_off_req[i] && !cool[i]
        && !chan_disconnect[i]) |=> chan_power_on[i])
      else $error("diagnostic power-on not immediate");

    // semi-auto without both enables starts detection
    a_semi_full_cycle: assert property (
      (semi && !both_en[i] && chan_on_req[i] && !chan_off_req[i]
        && !cool[i] && !chan_disconnect[i]) |=> (det_start[i] && !chan_power_on[i]))
      else $error("semi-auto power-on skipped detection");

    // auto with an enable cleared starts detection
    a_auto_one_cycle: assert property (
      (auto_m && !both_en[i] && chan_on_req[i] && !chan_off_req[i]
        && !cool[i] && !chan_disconnect[i]) |=> det_start[i])
      else $error("auto power-on did not start a cycle");

    // auto cycling powers without a request
    a_auto_self_on: assert property (
      s_auto_good |=> chan_power_on[i])
      else $error("auto cycle did not power channel");

    a_pulse_single: assert property (
      (det_en_set[i] && !$past(detect_restart_req[i]) && !cool[i])
        |-> !$past(det_en_set[i]))
      else $error("enable-set pulse repeated without request");

    // enable-set pulses only outside manual mode
    a_en_set_mode: assert property (
      det_en_set[i] |-> $past(semi || auto_m))
      else $error("enable set outside semi or auto mode");

    // no request and nothing held, no enable set
    a_zero_bit_idle: assert property (
      (semi && !cool[i] && !$past(cool[i]) && !detect_restart_req[i]) |=> !det_en_set[i])
      else $error("enable set without a restart bit");

    // an off pulse needs an off request
    a_off_needs_req: assert property (
      chan_power_off[i] |-> $past(chan_off_req[i]))
      else $error("off pulse without request");

    a_off_req_acts: assert property (
      (!off_m && chan_off_req[i]) |=> chan_power_off[i])
      else $error("off request did not turn off");

    // on and off never pulse together
    a_on_off_excl: assert property (
      chan_power_on[i] |-> !chan_power_off[i])
      else $error("on and off pulsed together");

    a_block_no_on: assert property (
      (cool[i] || chan_disconnect[i]) |=> !chan_power_on[i])
      else $error("turn-on while blocked");

    // off mode starts and enables nothing
    a_off_no_start: assert property (
      off_m |=> !(det_start[i] || cls_start[i] || det_en_set[i] || cls_en_set[i]))
      else $error("activity in off mode");

    // manual restarts never touch the enables
    a_manual_no_set: assert property (
      man |=> (!det_en_set[i] && !cls_en_set[i]))
      else $error("enable set in manual mode");

    a_semi_bad_det: assert property (
      (semi && det_done[i] && !det_valid[i]) |=> !cls_start[i])
      else $error("classification after failed detection");

    a_semi_bad_cls: assert property (
      (semi && cls_done[i] && !cls_valid[i]) |=> !chan_power_on[i])
      else $error("turn-on after failed classification");

    a_alloc_short: assert property (
      (!man && cls_done[i] && !alloc_ok[i]) |=> !chan_power_on[i])
      else $error("turn-on with short allocation");

    // armed request skips a fresh detection
    a_semi_armed: assert property (
      (semi && both_en[i] && !class_busy[i] && chan_on_req[i] && !chan_off_req[i]
        && !cool[i] && !chan_disconnect[i]) |=> !det_start[i])
      else $error("armed request started detection");

    // auto with both enables ignores power-on
    a_auto_both_idle: assert property (
      (auto_m && both_en[i] && chan_on_req[i]) |=> !det_start[i])
      else $error("auto power-on started a cycle");
  end

endmodule

`default_nettype wire

// *** testbench/pcpc_host_model.sv ***
/*
  Host-side model for the push-button block: issues single-byte
  command-code writes and reads.
  Assumes the block answers with reg_ack one cycle after each access.
*/
`timescale 1ns/1ps
`default_nettype none

module pcpc_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack
);
  // ----------------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // ----------------------------------------------------------------------
  // Accesses
  // ----------------------------------------------------------------------
  // allocation set first
  // Callers settle power allocation before any power-on write
  // restart as enable set
  // Restart writes may stand in for a read-modify-write of the enables
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released lines flip so a stale value is never mistaken for live
    reg_addr <= ~addr;
    reg_wdata <= ~data;
    #1;
  endtask

  // Answer sampled one cycle after the strobe, where it stands
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ack);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    #1;
    data = reg_rdata;
    ack = reg_ack;
  endtask
endmodule

`default_nettype wire

// *** testbench/pcpc_push_cmd_bench.sv ***
/*
  Self-checking bench for the push-button command block: one task per
  scenario, host accesses through the host model.
  Assumes the design settles registered pulses one cycle after a write.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module pcpc_push_cmd_bench;
  import pcpc_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk, rst, reg_wr, reg_rd, reg_ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, chan_mode;
  logic [3:0] class_cycle_en, detect_cycle_en, overload_cooldown, current_limit_cooldown;
  logic [3:0] startup_fault_cooldown, chan_disconnect, class_busy, det_done, det_valid;
  logic [3:0] cls_done, cls_valid, alloc_ok, det_start, cls_start, det_en_set, cls_en_set;
  logic [3:0] chan_power_on, chan_power_off, acc;
  logic [7:0] rd_data;
  logic rd_ack;
  int n_mismatch = 0;
  int num_checks = 0;

  pcpc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

  pcpc_push_cmd #(.NUM_CHAN(4)) dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .chan_mode(chan_mode), .class_cycle_en(class_cycle_en), .detect_cycle_en(detect_cycle_en),
    .overload_cooldown(overload_cooldown), .current_limit_cooldown(current_limit_cooldown),
    .startup_fault_cooldown(startup_fault_cooldown), .chan_disconnect(chan_disconnect),
    .class_busy(class_busy), .det_done(det_done), .det_valid(det_valid), .cls_done(cls_done),
    .cls_valid(cls_valid), .alloc_ok(alloc_ok), .det_start(det_start), .cls_start(cls_start),
    .det_en_set(det_en_set), .cls_en_set(cls_en_set), .chan_power_on(chan_power_on),
    .chan_power_off(chan_power_off));

  // ----------------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Fresh reset per scenario so no armed attempt leaks between them
  task automatic setup(input pcpc_mode_type m, input logic [3:0] cls_en, input logic [3:0] det_en);
    @(posedge clk);
    rst <= 1'b1;
    chan_mode <= {4{m}};
    class_cycle_en <= cls_en;
    detect_cycle_en <= det_en;
    overload_cooldown <= 4'h0;
    current_limit_cooldown <= 4'h0;
    startup_fault_cooldown <= 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  // One-cycle result pulse: kind 0 detection, 1 classification
  task automatic feed(input logic kind, input logic [3:0] m, input logic ok);
    @(posedge clk);
    if (kind == 1'b0) begin
      det_done <= m;
      det_valid <= ok ? m : 4'h0;
    end else begin
      cls_done <= m;
      cls_valid <= ok ? m : 4'h0;
    end
    @(posedge clk);
    det_done <= 4'h0;
    cls_done <= 4'h0;
    #1;
  endtask

  // OR of the det_start, cls_start and power pulses over n cycles
  task automatic quiet(input int n);
    acc = 4'h0;
    repeat (n) begin
      acc = acc | det_start | cls_start | chan_power_on | chan_power_off;
      @(posedge clk);
      #1;
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_restart();
    setup(MODE_MANUAL, 4'h0, 4'h0);
    host.write_reg(ADDR_RESTART, 8'h21);
    `CHK("restart ack", 1'b1, reg_ack)
    `CHK("det_start", 4'h1, det_start)
    `CHK("cls_start", 4'h2, cls_start)
    @(posedge clk);
    #1;
    `CHK("det_start cleared", 4'h0, det_start)
    host.read_reg(ADDR_RESTART, rd_data, rd_ack);
    `CHK("restart readback", READ_VALUE, rd_data)
    `CHK("read ack", 1'b1, rd_ack)
    host.read_reg(8'h20, rd_data, rd_ack);
    `CHK("unmapped ack", 1'b0, rd_ack)
    setup(MODE_SEMI, 4'h0, 4'h0);
    host.write_reg(ADDR_RESTART, 8'h84);
    `CHK("cls_en_set", 4'h8, cls_en_set)
    `CHK("det_en_set", 4'h4, det_en_set)
    `CHK("semi no start", 4'h0, det_start | cls_start)
  endtask

  task automatic t_restart_cool();
    setup(MODE_MANUAL, 4'h0, 4'h0);
    overload_cooldown <= 4'h1;
    host.write_reg(ADDR_RESTART, 8'h01);
    quiet(4);
    `CHK("held in cool-down", 4'h0, acc)
    overload_cooldown <= 4'h0;
    quiet(6);
    `CHK("issued after cool-down", 4'h1, acc)
    if (acc === 4'h0) final_report();
    // Cool-down ends right after the write
    overload_cooldown <= 4'h1;
    host.write_reg(ADDR_RESTART, 8'h01);
    overload_cooldown <= 4'h0;
    quiet(2);
    `CHK("held restart once", 4'h1, acc)
  endtask

  task automatic t_power();
    setup(MODE_MANUAL, 4'h0, 4'h0);
    host.write_reg(ADDR_POWER, 8'h0f);
    `CHK("manual on", 4'hf, chan_power_on)
    host.write_reg(ADDR_POWER, 8'hf0);
    `CHK("off all", 4'hf, chan_power_off)
    host.write_reg(ADDR_POWER, 8'h13);
    `CHK("both bits off", 4'h1, chan_power_off)
    `CHK("other on", 4'h2, chan_power_on)
    current_limit_cooldown <= 4'h2;
    startup_fault_cooldown <= 4'h4;
    host.write_reg(ADDR_POWER, 8'h06);
    quiet(3);
    `CHK("on in cool-down", 4'h0, acc)
    current_limit_cooldown <= 4'h0;
    startup_fault_cooldown <= 4'h0;
    quiet(4);
    `CHK("on discarded", 4'h0, acc)
    setup(MODE_OFF, 4'h0, 4'h0);
    host.write_reg(ADDR_POWER, 8'hff);
    quiet(4);
    `CHK("off mode ignored", 4'h0, acc)
  endtask

  task automatic t_cycle(input pcpc_mode_type m, input logic [3:0] ce, input logic [3:0] de);
    setup(m, ce, de);
    host.write_reg(ADDR_POWER, 8'h01);
    `CHK("attempt det_start", 4'h1, det_start)
    feed(1'b0, 4'h1, 1'b1);
    `CHK("attempt cls_start", 4'h1, cls_start)
    feed(1'b1, 4'h1, 1'b1);
    `CHK("attempt power on", 4'h1, chan_power_on)
    host.write_reg(ADDR_POWER, 8'h01);
    feed(1'b0, 4'h1, 1'b0);
    `CHK("bad detect stops", 4'h0, cls_start)
    feed(1'b1, 4'h1, 1'b1);
    `CHK("no retry", 4'h0, chan_power_on)
  endtask

  task automatic t_both();
    setup(MODE_SEMI, 4'hf, 4'hf);
    feed(1'b1, 4'h1, 1'b1);
    `CHK("semi needs request", 4'h0, chan_power_on)
    host.write_reg(ADDR_POWER, 8'h01);
    `CHK("armed no det_start", 4'h0, det_start)
    feed(1'b1, 4'h1, 1'b1);
    `CHK("armed power on", 4'h1, chan_power_on)
    // Classification already under way: full cycle instead
    class_busy <= 4'h1;
    host.write_reg(ADDR_POWER, 8'h01);
    `CHK("busy full cycle", 4'h1, det_start)
    class_busy <= 4'h0;
    setup(MODE_AUTO, 4'hf, 4'hf);
    feed(1'b1, 4'hf, 1'b1);
    `CHK("auto power on", 4'hf, chan_power_on)
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    chan_mode = 8'h00;
    {class_cycle_en, detect_cycle_en, overload_cooldown, current_limit_cooldown} = 16'h0000;
    {startup_fault_cooldown, chan_disconnect, class_busy} = 12'h000;
    {det_done, det_valid, cls_done, cls_valid} = 16'h0000;
    alloc_ok = 4'hf;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_restart();
    t_restart_cool();
    t_power();
    t_cycle(MODE_SEMI, 4'h0, 4'h1);
    t_cycle(MODE_AUTO, 4'h1, 4'h0);
    t_both();
    final_report();
  end
endmodule

`default_nettype wire
